// ---- seq_pkg.sv ----
// Shared constants, types and helpers for the home search and jog sequencer.
package seq_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each)
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_JOG_HI = 5'h04;
  localparam logic [4:0] ADDR_JOG_LO = 5'h08;
  localparam logic [4:0] ADDR_MAX_ACC = 5'h0c;
  localparam logic [4:0] ADDR_HOME_VEL = 5'h10;
  localparam logic [4:0] ADDR_STATUS = 5'h14;
  localparam logic [4:0] ADDR_POSITION = 5'h18;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_ABORT_BIT = 1;
  localparam int CTRL_JOG_HI_BIT = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_HOMED_BIT = 1;
  localparam int STAT_ORIGIN_BIT = 2;
  localparam int STAT_MOVING_BIT = 3;
  localparam int STAT_STATE_LSB = 4;

  // ---------------------------------------------------------------
  // Reset values and scaling
  // ---------------------------------------------------------------
  localparam logic [31:0] JOG_HI_RST = 32'h0000_1000;
  localparam logic [31:0] JOG_LO_RST = 32'h0000_0100;
  localparam logic [31:0] MAX_ACC_RST = 32'h0000_0800;
  localparam logic [31:0] HOME_VEL_RST = 32'h0000_0400;
  localparam logic [31:0] SLOW_DIVISOR = 32'h0000_000a;
  localparam logic [31:0] POS_RST = 32'h0000_0000;

  typedef enum logic [3:0] {
    IDLE, SEG_A, STOP_A, SEG_B, STOP_B, SEG_C, STOP_C, SEG_D, SEG_E
  } home_state_e;

  // Merges write data into a register under the Avalon byte enables.
  function automatic logic [31:0] apply_be(input logic [31:0] old,
                                           input logic [31:0] wdata,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return res;
  endfunction

endpackage

// ---- axis_if.sv ----
// Interface joining the input synchroniser, quadrature counter and sequencer.
`timescale 1ns/1ns
`default_nettype none
interface axis_if;
  logic enc_a;
  logic enc_b;
  logic index_rise;
  logic origin_lvl;
  logic origin_rise;
  logic origin_fall;
  logic [3:0] btn;
  logic pos_zero;
  logic [31:0] position;

  modport sync_mp (output enc_a, enc_b, index_rise, origin_lvl,
                   output origin_rise, origin_fall, btn);
  modport dec_mp (input enc_a, enc_b, pos_zero, output position);
  modport core_mp (input index_rise, origin_lvl, origin_rise, origin_fall,
                   input btn, position, output pos_zero);
endinterface
`default_nettype wire

// ---- input_sync.sv ----
// Two-flop synchroniser for all axis pins; edge detection for index and origin only.
`timescale 1ns/1ns
`default_nettype none
module input_sync (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Raw pins
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_index,
  input wire logic origin_sw,
  input wire logic [3:0] btn,
  // Synchronised side
  axis_if.sync_mp ax
);
  logic [7:0] meta_q;
  logic [7:0] sync_q;
  logic [1:0] last_q;
  logic [2:0] arm_q;

  // The first stage feeds only the second; edges use stages two and three.
  // Edges are held off until stage three holds a real pin sample, so a
  // switch that already stands high at reset gives no false edge.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= 8'h00;
      sync_q <= 8'h00;
      last_q <= 2'h0;
      arm_q <= 3'h0;
    end else begin
      meta_q <= {btn, origin_sw, enc_index, enc_b, enc_a};
      sync_q <= meta_q;
      last_q <= sync_q[3:2];
      arm_q <= {arm_q[1:0], 1'b1};
    end
  end

  // Each origin transition and each index rise yields exactly one pulse of one cycle.
  assign ax.enc_a = sync_q[0];
  assign ax.enc_b = sync_q[1];
  assign ax.index_rise = sync_q[2] & ~last_q[0] & arm_q[2];
  assign ax.origin_lvl = sync_q[3];
  assign ax.origin_rise = sync_q[3] & ~last_q[1] & arm_q[2];
  assign ax.origin_fall = ~sync_q[3] & last_q[1] & arm_q[2];
  assign ax.btn = sync_q[7:4];

  a_edge_once: assert property (@(posedge sys_clk) disable iff (!nrst)
    ax.origin_rise |=> !ax.origin_rise) else $error("double edge");
endmodule
`default_nettype wire

// ---- quad_counter.sv ----
// Four-edge quadrature decoder driving the axis position counter.
`timescale 1ns/1ns
`default_nettype none
module quad_counter
  import seq_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Encoder channels and counter
  axis_if.dec_mp ax
);
  logic pa_q;
  logic pb_q;
  logic [31:0] pos_q;
  logic step;
  logic up;

  // Exactly one channel changed; a double change is ignored.
  assign step = (ax.enc_a ^ pa_q) ^ (ax.enc_b ^ pb_q);
  assign up = ax.enc_a ^ pb_q;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pa_q <= 1'b0;
      pb_q <= 1'b0;
    end else begin
      pa_q <= ax.enc_a;
      pb_q <= ax.enc_b;
    end
  end

  // Every edge of either channel counts, four per cycle.
  // Power-on clears the count; a home reference clears it again.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pos_q <= POS_RST;
    end else if (ax.pos_zero) begin
      pos_q <= POS_RST;
    end else if (step) begin
      pos_q <= up ? pos_q + 32'h1 : pos_q - 32'h1;
    end
  end

  assign ax.position = pos_q;

  a_count_up: assert property (@(posedge sys_clk) disable iff (!nrst)
    step && up && !ax.pos_zero |=> ax.position == $past(pos_q) + 32'h1)
    else $error("up count wrong");
  a_double_skip: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ax.enc_a != pa_q) && (ax.enc_b != pb_q) && !ax.pos_zero |=>
    $stable(ax.position)) else $error("double change counted");
endmodule
`default_nettype wire

// ---- home_jog_seq.sv ----
// Top of the axis sequencer: registers, jog control and home search.
`timescale 1ns/1ns
`default_nettype none
module home_jog_seq
  import seq_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Avalon-MM register slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Encoder, origin switch and jog pins
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_index,
  input wire logic origin_sw,
  input wire logic jog_pos_btn,
  input wire logic jog_neg_btn,
  input wire logic digital_io_port_jog_pos,
  input wire logic digital_io_port_jog_neg,
  // Trajectory generator side
  input wire logic motion_stopped,
  output logic move_en,
  output logic move_dir,
  output logic [31:0] vel_cmd,
  output logic [31:0] accel_cmd,
  output logic display_suppress
);
  import seq_pkg::*;

  axis_if ax ();

  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] jog_hi_q;
  logic [31:0] jog_lo_q;
  logic [31:0] max_acc_q;
  logic [31:0] home_vel_q;
  logic jog_hi_sel_q;
  logic start_q;
  logic abort_q;
  logic homed_q;
  home_state_e state_q;
  logic move_en_q;
  logic move_dir_q;
  logic [31:0] vel_q;
  logic disp_q;
  logic move_en_d;
  logic move_dir_d;
  logic [31:0] vel_d;
  logic wr_take;
  logic zero_pulse;
  logic stop_seen;
  logic fp_pos;
  logic fp_neg;
  logic io_pos;
  logic io_neg;

  // ---------------------------------------------------------------
  // Input synchroniser and position counter
  // ---------------------------------------------------------------
  input_sync u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .enc_a(enc_a),
    .enc_b(enc_b),
    .enc_index(enc_index),
    .origin_sw(origin_sw),
    .btn({digital_io_port_jog_neg, digital_io_port_jog_pos, jog_neg_btn,
          jog_pos_btn}),
    .ax(ax.sync_mp)
  );

  quad_counter u_quad (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ax(ax.dec_mp)
  );

  assign fp_pos = ax.btn[0];
  assign fp_neg = ax.btn[1];
  assign io_pos = ax.btn[2];
  assign io_neg = ax.btn[3];

  // ---------------------------------------------------------------
  // Avalon slave: one wait cycle, then the access completes
  // ---------------------------------------------------------------

  // Holding waitrequest for one cycle gives read data a flop to settle in.
  assign waitrequest = (read | write) & ~ack_q;
  assign wr_take = write & ack_q;
  assign readdata = rdata_q;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (read | write) & ~ack_q;
    end
  end

  // Read data is captured during the wait cycle; unmapped reads give zero.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 32'h0000_0000;
    end else if (read && !ack_q) begin
      unique case (address)
        ADDR_CTRL: rdata_q <= 32'(jog_hi_sel_q) << CTRL_JOG_HI_BIT;
        ADDR_JOG_HI: rdata_q <= jog_hi_q;
        ADDR_JOG_LO: rdata_q <= jog_lo_q;
        ADDR_MAX_ACC: rdata_q <= max_acc_q;
        ADDR_HOME_VEL: rdata_q <= home_vel_q;
        ADDR_STATUS: rdata_q <= (32'(state_q) << STAT_STATE_LSB)
          | (32'(move_en_q) << STAT_MOVING_BIT)
          | (32'(ax.origin_lvl) << STAT_ORIGIN_BIT)
          | (32'(homed_q) << STAT_HOMED_BIT)
          | (32'(state_q != IDLE) << STAT_BUSY_BIT);
        ADDR_POSITION: rdata_q <= ax.position;
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Speed settings held in software registers.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      jog_hi_q <= JOG_HI_RST;
      jog_lo_q <= JOG_LO_RST;
      max_acc_q <= MAX_ACC_RST;
      home_vel_q <= HOME_VEL_RST;
      jog_hi_sel_q <= 1'b0;
    end else if (wr_take) begin
      unique case (address)
        ADDR_JOG_HI: jog_hi_q <= apply_be(jog_hi_q, writedata, byteenable);
        ADDR_JOG_LO: jog_lo_q <= apply_be(jog_lo_q, writedata, byteenable);
        ADDR_MAX_ACC: max_acc_q <= apply_be(max_acc_q, writedata, byteenable);
        ADDR_HOME_VEL: home_vel_q <= apply_be(home_vel_q, writedata,
                                              byteenable);
        ADDR_CTRL: begin
          if (byteenable[0]) begin
            jog_hi_sel_q <= writedata[CTRL_JOG_HI_BIT];
          end
        end
        default: ;
      endcase
    end
  end

  // Start and abort are one-cycle command pulses from the control word.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      start_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      start_q <= wr_take && address == ADDR_CTRL && byteenable[0]
                 && writedata[CTRL_START_BIT];
      abort_q <= wr_take && address == ADDR_CTRL && byteenable[0]
                 && writedata[CTRL_ABORT_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Home search sequencer
  // ---------------------------------------------------------------

  // The drive must have been released before a stop report is trusted,
  // so a stale stopped flag from the previous segment is not taken.
  assign stop_seen = !move_en_q && motion_stopped;
  assign zero_pulse = state_q == SEG_E && ax.index_rise && !abort_q;
  assign ax.pos_zero = zero_pulse;

  // A new start while busy is ignored; only abort breaks in.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= IDLE;
    end else if (abort_q) begin
      state_q <= IDLE;
    end else begin
      unique case (state_q)
        IDLE: begin
          if (start_q) begin
            // Origin high means the far side; travel down first.
            state_q <= ax.origin_lvl ? SEG_A : SEG_B;
          end
        end
        SEG_A: if (ax.origin_fall) state_q <= STOP_A;
        STOP_A: if (stop_seen) state_q <= SEG_B;
        SEG_B: if (ax.origin_rise) state_q <= STOP_B;
        STOP_B: if (stop_seen) state_q <= SEG_C;
        SEG_C: if (ax.origin_fall) state_q <= STOP_C;
        STOP_C: if (stop_seen) state_q <= SEG_D;
        // The switch edge hands straight over to the index search.
        SEG_D: if (ax.origin_rise) state_q <= SEG_E;
        // The first index after the switch edge ends the search.
        SEG_E: if (ax.index_rise) state_q <= IDLE;
      endcase
    end
  end

  // Homed flag: set by the reference, cleared when a new search starts.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      homed_q <= 1'b0;
    end else if (zero_pulse) begin
      homed_q <= 1'b1;
    end else if (start_q && state_q == IDLE) begin
      homed_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Motion command to the trajectory generator
  // ---------------------------------------------------------------

  // Segment speeds derive from the home speed; jog only when idle.
  always_comb begin
    move_en_d = 1'b0;
    move_dir_d = 1'b1;
    vel_d = 32'h0000_0000;
    unique case (state_q)
      SEG_A: begin
        move_en_d = 1'b1;
        move_dir_d = 1'b0;
        vel_d = home_vel_q;
      end
      SEG_B: begin
        move_en_d = 1'b1;
        vel_d = home_vel_q;
      end
      SEG_C: begin
        move_en_d = 1'b1;
        move_dir_d = 1'b0;
        vel_d = home_vel_q >> 1;
      end
      // Both slow segments run upward, so the index search is positive.
      SEG_D, SEG_E: begin
        move_en_d = 1'b1;
        move_dir_d = 1'b1;
        vel_d = home_vel_q / SLOW_DIVISOR;
      end
      IDLE: begin
        // Front panel picks high or low; pressing both panel directions falls through to the I/O port.
        if (fp_pos ^ fp_neg) begin
          move_en_d = 1'b1;
          move_dir_d = fp_pos;
          vel_d = jog_hi_sel_q ? jog_hi_q : jog_lo_q;
        end else if (io_pos ^ io_neg) begin
          move_en_d = 1'b1;
          move_dir_d = io_pos;
          vel_d = jog_lo_q;
        end
      end
      default: ;
    endcase
  end

  // Outputs are registered; release shows one cycle after the sync.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      move_en_q <= 1'b0;
      move_dir_q <= 1'b1;
      vel_q <= 32'h0000_0000;
      disp_q <= 1'b0;
    end else begin
      move_en_q <= move_en_d && !abort_q;
      move_dir_q <= move_dir_d;
      vel_q <= vel_d;
      disp_q <= state_q == SEG_E;
    end
  end

  assign move_en = move_en_q;
  assign move_dir = move_dir_q;
  assign vel_cmd = vel_q;
  assign accel_cmd = max_acc_q;
  assign display_suppress = disp_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_jog_release_halt: assert property (
    state_q == IDLE && !fp_pos && !fp_neg && !io_pos && !io_neg |=> !move_en)
    else $error("jog not halted");
  a_jog_hi_speed: assert property (
    state_q == IDLE && (fp_pos ^ fp_neg) && jog_hi_sel_q && !abort_q
    |=> move_en && vel_cmd == $past(jog_hi_q)) else $error("bad jog speed");
  a_accel_is_max: assert property (
    wr_take && address == ADDR_MAX_ACC && byteenable == 4'hf
    |=> accel_cmd == $past(writedata)) else $error("bad accel");
  a_io_one_speed: assert property (
    state_q == IDLE && !fp_pos && !fp_neg && (io_pos ^ io_neg) && !abort_q
    |=> vel_cmd == $past(jog_lo_q)) else $error("io port speed wrong");
  a_side_select: assert property (
    state_q == IDLE && start_q && !abort_q |=>
    state_q == ($past(ax.origin_lvl) ? SEG_A : SEG_B))
    else $error("wrong first segment");
  a_fast_speed: assert property (
    state_q == SEG_B && !abort_q |=> vel_cmd == $past(home_vel_q) && move_dir)
    else $error("fast segment wrong");
  a_half_speed: assert property (
    state_q == SEG_C && !abort_q |=> vel_cmd == $past(home_vel_q) >> 1
    && !move_dir) else $error("half speed wrong");
  a_slow_speed: assert property (
    state_q == SEG_D && !abort_q |=> vel_cmd == $past(home_vel_q) / 10)
    else $error("slow speed wrong");
  a_d_to_e_nostop: assert property (
    state_q == SEG_D && ax.origin_rise && !abort_q |=>
    state_q == SEG_E ##1 move_en) else $error("stop between slow segments");
  a_display_hold: assert property (
    state_q == SEG_E |=> display_suppress) else $error("display not held");
  a_index_zero: assert property (
    zero_pulse |=> ax.position == 32'h0 && homed_q && state_q == IDLE)
    else $error("reference not taken");
  a_index_positive: assert property (
    state_q == SEG_E ##1 state_q == SEG_E |-> move_dir)
    else $error("index search not positive");

  c_home_near: cover property (state_q == SEG_B ##[1:1000] zero_pulse);
  c_home_far: cover property (state_q == SEG_A ##[1:1000] state_q == SEG_E);
  c_jog_fp: cover property (move_en && state_q == IDLE ##1 !move_en);
endmodule
`default_nettype wire

// ---- axis_model.sv ----
// Behavioural stage: motor, quadrature encoder, index mark, origin switch.
`timescale 1ns/1ns
`default_nettype none
module axis_model #(
  parameter int ORG_POS = 200,
  parameter int IDX_PERIOD = 64,
  parameter int IDX_AT = 20,
  parameter int STEP_DIV = 8,
  parameter int OVERSHOOT = 2
) (
  // Clock
  input wire logic sys_clk,
  // Commands from the sequencer
  input wire logic move_en,
  input wire logic move_dir,
  // Sensor pins and motion status
  output logic enc_a,
  output logic enc_b,
  output logic enc_index,
  output logic origin_sw,
  output logic motion_stopped
);
  // ------------------------------------------------------------
  // Motor
  // ------------------------------------------------------------
  int pos = 100;
  int tick = 0;
  int coast = 0;
  logic dir_q = 1'b1;

  // One count per step; the stage coasts after the command drops, so
  // every stop overshoots the point where it was ordered.
  always @(posedge sys_clk) begin
    if (move_en) begin
      coast <= OVERSHOOT;
      dir_q <= move_dir;
    end
    tick <= (tick + 1) % STEP_DIV;
    if (tick == 0 && (move_en || coast > 0)) begin
      pos <= (move_en ? move_dir : dir_q) ? pos + 1 : pos - 1;
      if (!move_en) begin
        coast <= coast - 1;
      end
    end
  end

  // ------------------------------------------------------------
  // Sensors
  // ------------------------------------------------------------
  // Gray steps 00,10,11,01 upward: A leads B by a quarter cycle.
  always_comb begin
    enc_a = (pos & 3) == 1 || (pos & 3) == 2;
    enc_b = (pos & 3) >= 2;
    enc_index = (pos % IDX_PERIOD) == IDX_AT;
    origin_sw = pos >= ORG_POS;
    motion_stopped = !move_en && coast == 0;
  end
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the axis sequencer with a behavioural stage.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin \
  n_tests++; \
  if ((got) !== (exp)) begin \
    n_fail++; \
    $display("unexpected %s exp %h got %h", nm, exp, got); \
  end \
end
module testbench;
  import seq_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam logic [31:0] JH = 32'h0000_2222;
  localparam logic [31:0] JL = 32'h0000_0111;
  localparam logic [31:0] MA = 32'h0000_0abc;
  localparam logic [31:0] HV = 32'h0000_03e8;
  localparam int IDX_POS = 212; // First index mark above the transition.
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hf;
  logic jog_pos_btn = 1'b0, jog_neg_btn = 1'b0;
  logic digital_io_port_jog_pos = 1'b0;
  logic digital_io_port_jog_neg = 1'b0;
  wire logic [31:0] readdata, vel_cmd, accel_cmd;
  wire logic waitrequest, move_en, move_dir, display_suppress;
  wire logic enc_a, enc_b, enc_index, origin_sw, motion_stopped;
  int n_fail = 0;
  int n_tests = 0;
  int n_ds = 0;
  int m0;
  logic [31:0] q, p0;
  logic [32:0] segs[$];
  logic me_q = 1'b0;
  logic [4:0] ra[6] = '{ADDR_JOG_HI, ADDR_JOG_LO, ADDR_MAX_ACC,
                        ADDR_HOME_VEL, ADDR_POSITION, 5'h1c};
  logic [31:0] rv[6] = '{JOG_HI_RST, JOG_LO_RST, MAX_ACC_RST,
                         HOME_VEL_RST, POS_RST, 32'h0};
  logic [31:0] nv[6] = '{JH, JL, MA, HV, 32'h1234_5678, 32'h1234_5678};

  always #4 sys_clk = ~sys_clk;

  home_jog_seq i_dut (.sys_clk(sys_clk), .nrst(nrst), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .enc_a(enc_a), .enc_b(enc_b),
    .enc_index(enc_index), .origin_sw(origin_sw),
    .jog_pos_btn(jog_pos_btn), .jog_neg_btn(jog_neg_btn),
    .digital_io_port_jog_pos(digital_io_port_jog_pos),
    .digital_io_port_jog_neg(digital_io_port_jog_neg),
    .motion_stopped(motion_stopped), .move_en(move_en),
    .move_dir(move_dir), .vel_cmd(vel_cmd), .accel_cmd(accel_cmd),
    .display_suppress(display_suppress));

  axis_model stage (.sys_clk(sys_clk), .move_en(move_en),
    .move_dir(move_dir), .enc_a(enc_a), .enc_b(enc_b),
    .enc_index(enc_index), .origin_sw(origin_sw),
    .motion_stopped(motion_stopped));

  // ------------------------------------------------------------
  // Monitors
  // ------------------------------------------------------------
  // Logs each new motion segment; sampled mid-cycle so outputs are settled.
  always @(negedge sys_clk) begin
    if (move_en === 1'b1 &&
        (me_q !== 1'b1 || {move_dir, vel_cmd} !== segs[$])) begin
      segs.push_back({move_dir, vel_cmd});
    end
    me_q <= move_en;
  end

  // The index search must start from a running, slow, upward move.
  always @(posedge display_suppress) begin
    n_ds++;
    `CHK("seg_e", {1'b1, HV / SLOW_DIVISOR, 1'b1}, {move_dir, vel_cmd, move_en})
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One Avalon access; the request stands until waitrequest is seen low
  // at a rising edge, and read data is taken at that same edge.
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= d;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      n_fail++;
      finish_test();
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  // Runs a search from below or above the switch; the bus stays quiet.
  task automatic home(input logic far);
    int n;
    @(posedge sys_clk);
    stage.pos <= (stage.pos & 3) + (far ? 300 : 100);
    repeat (4) @(posedge sys_clk);
    segs.delete();
    n_ds = 0;
    bus(1'b1, ADDR_CTRL, 32'h1);
    for (n = 0; n < 30000; n++) begin
      @(posedge sys_clk);
      if (n_ds > 0 && display_suppress === 1'b0 &&
          motion_stopped === 1'b1) break;
    end
    if (n == 30000) begin
      n_fail++;
      finish_test();
    end
    if (far) `CHK("seg_a", {1'b0, HV}, segs.pop_front())
    `CHK("seg_b", {1'b1, HV}, segs.pop_front())
    `CHK("seg_c", {1'b0, HV >> 1}, segs.pop_front())
    `CHK("seg_d", {1'b1, HV / SLOW_DIVISOR}, segs.pop_front())
    `CHK("n_seg", 0, segs.size())
    `CHK("n_ds", 1, n_ds)
    bus(1'b0, ADDR_STATUS, 32'h0);
    `CHK("homed", 2'b10, q[1:0])
    bus(1'b0, ADDR_POSITION, 32'h0);
    `CHK("home_pos", 32'(stage.pos - IDX_POS), q)
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    `CHK("acc_rst", MAX_ACC_RST, accel_cmd)
    for (int k = 0; k < 6; k++) begin
      bus(1'b0, ra[k], 32'h0);
      `CHK("reg_rst", rv[k], q)
      bus(1'b1, ra[k], nv[k]);
      bus(1'b0, ra[k], 32'h0);
      `CHK("reg_wr", k < 4 ? nv[k] : rv[k], q)
    end
    // Front panel high and low, then the I/O port with high selected.
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, ADDR_CTRL, (i == 1) ? 32'h0 : 32'h4);
      bus(1'b0, ADDR_POSITION, 32'h0);
      p0 = q;
      m0 = stage.pos;
      @(posedge sys_clk);
      jog_pos_btn <= (i == 0);
      jog_neg_btn <= (i == 1);
      digital_io_port_jog_pos <= (i == 2);
      digital_io_port_jog_neg <= (i == 3);
      repeat (40) @(posedge sys_clk);
      `CHK("jog", {1'b1, i[0] == 1'b0, i == 0 ? JH : JL}, {move_en, move_dir, vel_cmd})
      `CHK("jog_acc", MA, accel_cmd)
      jog_pos_btn <= 1'b0;
      jog_neg_btn <= 1'b0;
      digital_io_port_jog_pos <= 1'b0;
      digital_io_port_jog_neg <= 1'b0;
      repeat (4) @(posedge sys_clk);
      `CHK("jog_halt", 1'b0, move_en)
      repeat (30) @(posedge sys_clk);
      bus(1'b0, ADDR_POSITION, 32'h0);
      `CHK("count", 32'(stage.pos - m0), q - p0)
    end
    // Both channels jump at once while idle; the count must hold still.
    bus(1'b0, ADDR_POSITION, 32'h0);
    p0 = q;
    stage.pos <= stage.pos + 2;
    repeat (8) @(posedge sys_clk);
    bus(1'b0, ADDR_POSITION, 32'h0);
    `CHK("dbl_skip", p0, q)
    home(1'b0);
    home(1'b1);
    // An emergency abort must stop the search at once.
    bus(1'b1, ADDR_CTRL, 32'h1);
    repeat (20) @(posedge sys_clk);
    bus(1'b1, ADDR_CTRL, 32'h2);
    repeat (3) @(posedge sys_clk);
    `CHK("abort_move", 1'b0, move_en)
    bus(1'b0, ADDR_STATUS, 32'h0);
    `CHK("abort_busy", 1'b0, q[STAT_BUSY_BIT])
    finish_test();
  end
endmodule
`default_nettype wire
